// >>> verilog/supervision_timer_pkg.sv
// supervision timer package: register layout, reset values, timing counts
// assumes a 25 MHz pclk and an apb slave with 32-bit data
package supervision_timer_pkg;
  // register byte offsets
  localparam logic [11:0] count_reg_off = 12'h000;
  localparam logic [11:0] status_reg_off = 12'h004;
  localparam logic [11:0] mask_reg_off = 12'h008;
  localparam logic [11:0] option_reg_off = 12'h00c;
  // field positions of the count register
  localparam int activate_pos = 0;
  localparam int soft_reset_pos = 1;
  localparam int countdown_lsb_pos = 7;
  localparam logic [7:0] count_reset_value = 8'hfe;
  // status bits
  localparam int st_expiry_pos = 0;
  localparam int st_soft_pos = 1;
  localparam int st_tick_pos = 2;
  localparam int status_width = 3;
  // option register bits
  localparam int opt_stop_pos = 0;
  // timing
  localparam int decrement_cycles = 3072;
  localparam int clk_period_ns = 40;
  localparam int reset_pulse_ns = 500;
  localparam int reset_pulse_cycles =
    (reset_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int tick_width = 12;
  localparam int pulse_width = 5;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_armed = 2'b01,
    st_reset = 2'b10
  } wd_state_t;
endpackage

// >>> verilog/supervision_timer.sv
// seven-bit supervision timer with apb registers and reset pulse generation
// assumes activation_option and stop pins arrive asynchronously
//
// How it works
// RULE1 - hardware option keeps the watchdog active, activate bit forced high
// RULE2 - under hardware option the read activate bit is not trustworthy
// RULE3 - software option: inactive after reset, activated by writing one
// RULE4 - once active, writes clearing the activate bit are ignored
// RULE5 - seven counter bits decrement once every 3072 clocks
// RULE6 - six countdown bits give 64 programmable timeout steps
// RULE7 - active and soft reset bit zero starts a 500ns reset pulse
// RULE8 - software refreshes the counter with FEh down to 02h
// RULE9 - each refresh keeps the soft reset bit at one
// RULE10 - writing soft reset bit zero while active resets at once
// RULE11 - timeout scales as value times 3072 clocks
// RULE12 - inactive under software option the counter runs as a timer
// RULE13 - software reads the timer twice and compares
// RULE14 - software option: if activate found set, write 0FDh to reset
// RULE15 - countdown bits are stored bit-reversed, activate at bit 0
// RULE16 - inactive, soft reset bit clearing causes no reset
// RULE17 - active with stop control, stop with nmi high freezes counter
// RULE18 - reset request is one registered pulse on pclk
`timescale 1ns/10ps
`default_nettype none

module supervision_timer
  import supervision_timer_pkg::*;
#(
  parameter int decrement_count = decrement_cycles
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // option and stop inputs
  input wire logic activation_option,
  input wire logic external_stop_control_option,
  input wire logic stop_request,
  input wire logic nmi_pin,
  // outputs
  output logic reset_request,
  output logic reset_pin_n,
  output logic stop_granted,
  output logic irq
);

  apb_req_t req;
  apb_rsp_t rsp;
  logic [1:0] hw_opt_sync_reg;
  logic [1:0] stop_ctl_sync_reg;
  logic [1:0] stop_sync_reg;
  logic [1:0] nmi_sync_reg;
  logic [6:0] count_reg;
  logic active_reg;
  logic [tick_width-1:0] tick_reg;
  logic tick;
  logic frozen;
  logic wr_count;
  logic soft_clear;
  logic expire;
  logic reset_req_reg;
  logic [pulse_width-1:0] pulse_reg;
  wd_state_t state_reg;
  logic [status_width-1:0] status_reg;
  logic [status_width-1:0] mask_reg;
  logic [status_width-1:0] events;
  logic [31:0] rdata_reg;
  logic [6:0] count_next;
  logic start_reset;
  logic status_clear;
  logic mask_write;
  logic read_setup;

  // bit-reversed placement: bit 7 is counter lsb
  function automatic logic [7:0] pack_count(input logic [6:0] c,
                                            input logic act);
    logic [7:0] r;
    r = 8'h00;
    r[activate_pos] = act;
    r[soft_reset_pos] = c[6];
    for (int i = 0; i < 6; i++) begin
      r[countdown_lsb_pos - i] = c[i];
    end
    return r;
  endfunction

  function automatic logic [6:0] unpack_count(input logic [7:0] r);
    logic [6:0] c;
    c = 7'h00;
    c[6] = r[soft_reset_pos];
    for (int i = 0; i < 6; i++) begin
      c[i] = r[countdown_lsb_pos - i];
    end
    return c;
  endfunction

  // write access strobe for one register offset
  function automatic logic write_hit(input apb_req_t r,
                                     input logic [11:0] off);
    return r.sel && r.enable && r.write && r.addr == off;
  endfunction

  localparam logic [6:0] count_init = unpack_count(count_reset_value);

  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};
  assign rsp = '{ready: 1'b1, slverr: 1'b0, rdata: rdata_reg};
  assign pready = rsp.ready;
  assign pslverr = rsp.slverr;
  assign prdata = rsp.rdata;

  // input synchronisers, two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_opt_sync_reg <= 2'b00;
    end else begin
      hw_opt_sync_reg <= {hw_opt_sync_reg[0], activation_option};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ctl_sync_reg <= 2'b00;
    end else begin
      stop_ctl_sync_reg <= {stop_ctl_sync_reg[0],
                            external_stop_control_option};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_sync_reg <= 2'b00;
    end else begin
      stop_sync_reg <= {stop_sync_reg[0], stop_request};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_sync_reg <= 2'b00;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin};
    end
  end

  assign wr_count = write_hit(req, count_reg_off);
  assign status_clear = write_hit(req, status_reg_off);
  assign mask_write = write_hit(req, mask_reg_off);
  assign read_setup = req.sel && !req.enable && !req.write;
  // freeze only when active, stop control on, stop with nmi high
  assign frozen = active_reg && stop_ctl_sync_reg[1] && stop_sync_reg[1] &&
                  nmi_sync_reg[1]; // RULE17
  assign stop_granted = frozen || (!active_reg && stop_sync_reg[1]);

  // prescaler of 3072 clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= '0;
    end else if (frozen) begin
      tick_reg <= tick_reg; // RULE17
    end else if (tick) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end
  assign tick = !frozen &&
    tick_reg == tick_width'(decrement_count - 1); // RULE5 RULE11

  // activation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 1'b0; // RULE3
    end else if (hw_opt_sync_reg[1]) begin
      active_reg <= 1'b1; // RULE1
    end else if (wr_count && req.wdata[activate_pos]) begin
      active_reg <= 1'b1; // RULE3
    end // RULE4
  end

  // counter
  always_comb begin
    count_next = count_reg - 7'h01; // RULE5 RULE12
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= count_init;
    end else if (wr_count) begin
      count_reg <= unpack_count(req.wdata[7:0]); // RULE6 RULE15
    end else if (tick) begin
      count_reg <= count_next;
    end
  end

  // reset request sources; inactive, soft bit has no reset effect
  assign soft_clear = wr_count && !req.wdata[soft_reset_pos] &&
                      active_reg; // RULE10 RULE16
  assign expire = tick && active_reg && !wr_count &&
                  count_reg[6] && !count_next[6]; // RULE7 RULE16

  // reset sequencer; events during the pulse are ignored
  assign start_reset = state_reg == st_idle && (soft_clear || expire);

  // one-cycle reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= start_reset; // RULE18
    end
  end

  // pin-low length counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg <= '0;
    end else if (start_reset) begin
      pulse_reg <= pulse_width'(reset_pulse_cycles); // RULE7
    end else if (state_reg == st_reset) begin
      pulse_reg <= pulse_reg - 1'b1;
    end
  end

  // sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: begin
          if (start_reset) begin
            state_reg <= st_reset;
          end
        end
        st_reset: begin
          if (pulse_reg == pulse_width'(1)) begin
            state_reg <= st_idle;
          end
        end
        default: begin
          state_reg <= st_idle;
        end
      endcase
    end
  end
  assign reset_request = reset_req_reg;
  assign reset_pin_n = state_reg != st_reset;

  // sticky status, write one to clear, set wins
  assign events = {tick, soft_clear, expire};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < status_width; i++) begin
        if (events[i]) begin
          status_reg[i] <= 1'b1;
        end else if (status_clear && req.wdata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= '0;
    end else if (mask_write) begin
      mask_reg <= req.wdata[status_width-1:0];
    end
  end
  assign irq = |(status_reg & mask_reg);

  // read data; activate bit reads the live active flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
    end else if (read_setup) begin
      case (req.addr)
        count_reg_off: // RULE2
          rdata_reg <= {24'h000000, pack_count(count_reg, active_reg)};
        status_reg_off:
          rdata_reg <= {29'h0, status_reg};
        mask_reg_off:
          rdata_reg <= {29'h0, mask_reg};
        option_reg_off:
          rdata_reg <= {30'h0, stop_ctl_sync_reg[1], hw_opt_sync_reg[1]};
        default:
          rdata_reg <= '0;
      endcase
    end
  end

endmodule // supervision_timer

`default_nettype wire

// >>> verification/supervision_timer_checker.sv
// checker for the supervision timer ports
// assumes it is bound into supervision_timer, one clock pclk
`timescale 1ns/10ps
`default_nettype none
module supervision_timer_checker
  import supervision_timer_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // option and reset
  input wire logic activation_option,
  input wire logic reset_request,
  input wire logic reset_pin_n
);
  logic act_seen;
  logic [2:0] opt_cnt;
  wire logic acc = psel && penable && paddr == count_reg_off;
  wire logic wr0 = acc && pwrite;
  wire logic rd0 = acc && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) act_seen <= 1'b0;
    else if (wr0 && pwdata[activate_pos]) act_seen <= 1'b1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) opt_cnt <= 3'h0;
    else if (!activation_option) opt_cnt <= 3'h0;
    else if (opt_cnt != 3'h7) opt_cnt <= opt_cnt + 3'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence pin_low_s;
    !reset_pin_n [*8] ##1 !reset_pin_n [*5];
  endsequence
  access_ready_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access not ready");
  soft_reset_a: assert property (
    wr0 && !pwdata[soft_reset_pos] && reset_pin_n &&
    (act_seen || opt_cnt == 3'h7) |=> reset_request)
    else $error("soft reset missing");
  arm_needed_a: assert property (
    reset_request |-> act_seen || opt_cnt != 3'h0)
    else $error("reset while inactive");
  act_sticky_a: assert property (
    rd0 && act_seen |-> prdata[activate_pos])
    else $error("activate bit lost");
  act_idle_a: assert property (
    rd0 && !act_seen && opt_cnt == 3'h0 |-> !prdata[activate_pos])
    else $error("active without write");
  pulse_single_a: assert property (reset_request |=> !reset_request)
    else $error("request longer than one cycle");
  pin_pulse_a: assert property (
    reset_request |-> pin_low_s ##1 reset_pin_n)
    else $error("reset pin pulse length");
  pin_cause_a: assert property ($fell(reset_pin_n) |-> reset_request)
    else $error("pin low without request");
endmodule // supervision_timer_checker
bind supervision_timer supervision_timer_checker supervision_timer_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .activation_option(activation_option),
  .reset_request(reset_request), .reset_pin_n(reset_pin_n));
`default_nettype wire

// >>> verification/supervision_timer_tb.sv
// self-checking bench for supervision_timer
// assumes package and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module supervision_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic opt, ext, stp, nmi, rreq, pin_n, grant, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] v;
  int errors, comparisons, n, k;
  supervision_timer #(.decrement_count(16)) supervision_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .activation_option(opt),
    .external_stop_control_option(ext), .stop_request(stp),
    .nmi_pin(nmi), .reset_request(rreq), .reset_pin_n(pin_n),
    .stop_granted(grant), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [6:0] un(input logic [7:0] r);
    return {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt;
    n = 0;
    while (rreq !== 1'b1 && n < 1100) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic rst;
    repeat (16) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic expire(input logic [7:0] r);
    r = r | 8'h03;
    k = un(r) - 63;
    apb(1'b1, 12'h0, r);
    wt;
    chk("timeout", 1, n >= (k - 1) * 16 && n <= k * 16 + 3);
    rst;
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    wrap_up;
  end
  initial begin
    {psel, penable, pwrite, opt, ext, stp, nmi, presetn} = 8'h00;
    paddr = 12'h0;
    pwdata = 32'h0;
    void'($urandom(32'hb99b));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h0, 8'h0);
    chk("count reset", 32'hfe, rd);
    repeat (4) begin
      v = 8'($urandom) | 8'h02 & 8'hfe;
      k = 1 + $urandom % 3;
      apb(1'b1, 12'h0, v & 8'hfe);
      repeat (k * 16) @(posedge pclk);
      apb(1'b0, 12'h0, 8'h0);
      n = un(v & 8'hfe) - un(rd[7:0]);
      chk("timer", 1, n >= k - 1 && n <= k + 1);
      chk("inactive", 0, rd[0]);
    end
    apb(1'b1, 12'h0, 8'h04);
    repeat (4) @(posedge pclk);
    chk("no reset", 1, pin_n);
    apb(1'b1, 12'h0, 8'hff);
    apb(1'b1, 12'h0, 8'hfe);
    apb(1'b0, 12'h0, 8'h0);
    chk("active", 1, rd[0]);
    apb(1'b1, 12'h0, 8'hfd);
    wt;
    chk("soft reset", 1, n <= 3);
    apb(1'b0, 12'h4, 8'h0);
    chk("status", 1, rd[1]);
    chk("masked", 0, irq);
    apb(1'b1, 12'h8, 8'h02);
    @(posedge pclk);
    chk("irq", 1, irq);
    apb(1'b1, 12'h4, 8'h02);
    @(posedge pclk);
    chk("irq clear", 0, irq);
    apb(1'b1, 12'h10, 8'h5);
    apb(1'b0, 12'h10, 8'h0);
    chk("unmapped", 0, rd);
    rst;
    expire(8'h02);
    expire(8'hfe);
    expire(8'($urandom));
    opt <= 1'b1;
    rst;
    apb(1'b1, 12'h0, 8'hfc);
    wt;
    chk("hw option", 1, n <= 3);
    opt <= 1'b0;
    rst;
    {ext, stp, nmi} <= 3'b111;
    apb(1'b1, 12'h0, 8'hff);
    apb(1'b0, 12'h0, 8'h0);
    v = rd[7:0];
    chk("frozen start", 32'hff, rd);
    repeat (40) @(posedge pclk);
    apb(1'b0, 12'h0, 8'h0);
    chk("frozen", {24'h0, v}, rd);
    chk("stop granted", 1, grant);
    nmi <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("stop as wait", 0, grant);
    repeat (40) @(posedge pclk);
    apb(1'b0, 12'h0, 8'h0);
    chk("resumed", 1, rd[7:0] != v);
    wrap_up;
  end
endmodule // supervision_timer_tb
`default_nettype wire
